// ===== logic/mmp_map.vh
// Purpose: constants for the memory map page register bank
// Assumes: apb byte addresses are four times the printed register index
// Notes:   definitions only
`ifndef MMP_MAP_VH
`define MMP_MAP_VH
`define MMP_IDX_MODE      8'h0b
`define MMP_IDX_GLOBAL_PAGE_INDEX     8'h10
`define MMP_IDX_DIRECT    8'h11
`define MMP_IDX_VISCTL    8'h13
`define MMP_IDX_PROGRAM_PAGE_INDEX     8'h15
`define MMP_IDX_STATUS    8'h20
`define MMP_MODE_BIT      7
`define MMP_VIS_SCRATCH   7
`define MMP_VIS_DATAIFR   5
`define MMP_VIS_PROGIFR   4
`define MMP_VIS_MASK      8'hb0
`define MMP_GLOBAL_PAGE_INDEX_RST     7'h00
`define MMP_DIRECT_RST    8'h00
`define MMP_VIS_RST       8'h00
`define MMP_PROGRAM_PAGE_INDEX_RST     8'hfe
`define MMP_PROGRAM_PAGE_INDEX_FIXED   8'hff
`define MMP_PIFR_BASE     23'h400000
`define MMP_PIFR_LAST     23'h403fff
`endif

// ===== logic/mmp_memory_map_page_registers.v
// Purpose: page and mode registers of the memory mapping controller
// Assumes: apb slave, 32-bit data, single clock clk_sys at 40 MHz
// Notes:   address outputs are registered, one cycle after the inputs
//
// Contract
// - mode follows the mode pin in reset, latched into bit 7 at release.
// - a refused mode transition leaves the bit and locks it outside special mode.
// - mode register writes are ignored while the device is secured.
// - global load/store address is global page bits over the cpu local address.
// - global page index is seven bits, read and write anytime, 128 pages.
// - direct page writes anytime in special mode, once only in normal mode.
// - direct addressing takes address bits 15:8 from the direct page register.
// - global direct access takes top bits from global page, else local expansion.
// - direct page placement applies to global and local mapping.
// - bit 7 of visibility control shows scratch ram in the global map.
// - bit 5 of visibility control shows the data flash information row.
// - bit 4 maps the program information row to 0x40_0000-0x40_3fff.
// - program page index selects the 16KB flash block in window 0x8000-0xbfff.
// - cpu may read and write the program page index during far call and return.
// - program page index resets to 0xfe.
// - local range 0xc000-0xffff always maps to program page 0xff.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "mmp_map.vh"
module mmp_memory_map_page_registers (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        clkEn,
   input  wire        modePin,
   input  wire        secured,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire [15:0] localAddr,
   input  wire        globalInstr,
   input  wire        directMode,
   input  wire        farPageWrite,
   input  wire [7:0]  farPageData,
   output wire [7:0]  farPageRead,
   output reg  [22:0] globalAddr_r,
   output wire        specialMode,
   output wire        scratchRamVisible,
   output wire        dataInfoRowVisible,
   output wire        programInfoRowVisible,
   output reg         progInfoRowHit_r
);
   reg        modeSync1_r;
   reg        modeSync2_r;
   reg        modeSync3_r;
   reg        inReset_r;
   reg [1:0]  modeFill_r;
   reg        mode_select_bit_r;
   reg        modeLock_r;
   reg [6:0]  global_page_bits_r;
   reg [7:0]  direct_page_bits_r;
   reg        directWritten_r;
   reg [7:0]  visibility_r;
   reg [7:0]  program_page_bits_r;
   reg [22:0] globalAddr_nxt;
   reg [15:0] effLocal;
   reg [31:0] rdMux;
   reg        hitMap;

   wire       access  = psel & penable;
   wire       wrEn    = access & pwrite & pstrb[0] & clkEn;
   wire [9:0] regIdx  = paddr[11:2];
   wire       alignOk = (paddr[1:0] == 2'b00);

   function [22:0] expandLocal;
      input [15:0] la;
      input [7:0]  page;
      begin
         if (la[15:14] == 2'b11)
            expandLocal = {1'b1, `MMP_PROGRAM_PAGE_INDEX_FIXED, la[13:0]};
         else if (la[15:14] == 2'b10)
            expandLocal = {1'b1, page, la[13:0]};
         else
            expandLocal = {7'h00, la};
      end
   endfunction

   function isReg;
      input [9:0] idx;
      input [7:0] want;
      begin
         isReg = (idx == {2'b00, want});
      end
   endfunction

   assign pready  = 1'b1;
   assign pslverr = access & (~hitMap | ~alignOk);
   assign specialMode = ~mode_select_bit_r;
   assign scratchRamVisible     = visibility_r[`MMP_VIS_SCRATCH];
   assign dataInfoRowVisible    = visibility_r[`MMP_VIS_DATAIFR];
   assign programInfoRowVisible = visibility_r[`MMP_VIS_PROGIFR];
   assign farPageRead = program_page_bits_r;

   always @* begin
      hitMap = isReg(regIdx, `MMP_IDX_MODE) | isReg(regIdx, `MMP_IDX_GLOBAL_PAGE_INDEX) |
               isReg(regIdx, `MMP_IDX_DIRECT) | isReg(regIdx, `MMP_IDX_VISCTL) |
               isReg(regIdx, `MMP_IDX_PROGRAM_PAGE_INDEX) | isReg(regIdx, `MMP_IDX_STATUS);
      rdMux = 32'h00000000;
      if (isReg(regIdx, `MMP_IDX_MODE))
         rdMux = {24'h000000, mode_select_bit_r, 7'h00};
      else if (isReg(regIdx, `MMP_IDX_GLOBAL_PAGE_INDEX))
         rdMux = {25'h0000000, global_page_bits_r};
      else if (isReg(regIdx, `MMP_IDX_DIRECT))
         rdMux = {24'h000000, direct_page_bits_r};
      else if (isReg(regIdx, `MMP_IDX_VISCTL))
         rdMux = {24'h000000, visibility_r};
      else if (isReg(regIdx, `MMP_IDX_PROGRAM_PAGE_INDEX))
         rdMux = {24'h000000, program_page_bits_r};
      else if (isReg(regIdx, `MMP_IDX_STATUS))
         rdMux = {29'h00000000, secured, directWritten_r, modeLock_r};
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         prdata <= 32'h00000000;
      else if (clkEn & psel & ~penable & ~pwrite)
         prdata <= rdMux;
   end

   // pin crossing, three stages
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         modeSync1_r <= 1'b0;
         modeSync2_r <= 1'b0;
         modeSync3_r <= 1'b0;
         inReset_r   <= 1'b1;
         modeFill_r  <= 2'b00;
      end else if (clkEn) begin
         modeSync1_r <= modePin;
         modeSync2_r <= modeSync1_r;
         modeSync3_r <= modeSync2_r;
         // stages hold reset zeros until filled, so wait before trusting them
         modeFill_r  <= {modeFill_r[0], 1'b1};
         if (modeFill_r[1] & (modeSync2_r == modeSync3_r))
            inReset_r <= 1'b0;
      end
   end

   // mode bit and its lock
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_select_bit_r <= 1'b0;
         modeLock_r        <= 1'b0;
      end else if (clkEn) begin
         if (inReset_r) begin
            if (modeFill_r[1] & (modeSync2_r == modeSync3_r))
               mode_select_bit_r <= modeSync3_r;
         end else if (wrEn & isReg(regIdx, `MMP_IDX_MODE) & ~secured) begin
            if (~mode_select_bit_r)
               mode_select_bit_r <= pwdata[`MMP_MODE_BIT];
            else if (~pwdata[`MMP_MODE_BIT])
               modeLock_r <= 1'b1;
         end
      end
   end

   // page and control registers
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         global_page_bits_r  <= `MMP_GLOBAL_PAGE_INDEX_RST;
         direct_page_bits_r  <= `MMP_DIRECT_RST;
         directWritten_r     <= 1'b0;
         visibility_r        <= `MMP_VIS_RST;
         program_page_bits_r <= `MMP_PROGRAM_PAGE_INDEX_RST;
      end else if (clkEn) begin
         if (wrEn & isReg(regIdx, `MMP_IDX_GLOBAL_PAGE_INDEX))
            global_page_bits_r <= pwdata[6:0];
         if (wrEn & isReg(regIdx, `MMP_IDX_DIRECT) & (specialMode | ~directWritten_r)) begin
            direct_page_bits_r <= pwdata[7:0];
            directWritten_r    <= 1'b1;
         end
         if (wrEn & isReg(regIdx, `MMP_IDX_VISCTL))
            visibility_r <= pwdata[7:0] & `MMP_VIS_MASK;
         // far call wins, completes same cycle
         if (farPageWrite)
            program_page_bits_r <= farPageData;
         else if (wrEn & isReg(regIdx, `MMP_IDX_PROGRAM_PAGE_INDEX))
            program_page_bits_r <= pwdata[7:0];
      end
   end

   // address translation
   always @* begin
      effLocal = localAddr;
      if (directMode)
         effLocal = {direct_page_bits_r, localAddr[7:0]};
      if (globalInstr)
         globalAddr_nxt = {global_page_bits_r, effLocal};
      else
         globalAddr_nxt = expandLocal(effLocal, program_page_bits_r);
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         globalAddr_r     <= 23'h000000;
         progInfoRowHit_r <= 1'b0;
      end else if (clkEn) begin
         globalAddr_r     <= globalAddr_nxt;
         progInfoRowHit_r <= programInfoRowVisible & (globalAddr_nxt >= `MMP_PIFR_BASE) &
                             (globalAddr_nxt <= `MMP_PIFR_LAST);
      end
   end
endmodule // mmp_memory_map_page_registers

// ===== verification/mmp_checker_assertions.sv
// Purpose: port checks for the page register bank
// Assumes: byte address is four times the index
// Notes:   ready, slave error, mode bit and program page
`timescale 1ns/1ps
module mmp_checker (
   input wire        clk_sys,
   input wire        rst,
   input wire        clkEn,
   input wire        modePin,
   input wire        secured,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire        pready,
   input wire        pslverr,
   input wire        farPageWrite,
   input wire [7:0]  farPageData,
   input wire [7:0]  farPageRead,
   input wire        specialMode
);
   wire wr = clkEn && psel && penable && pwrite;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_READY: assert property (psel && penable |-> pready) else $error("no ready");
   AST_UNMAPPED: assert property (psel && penable && paddr == 12'h0f0 |-> pslverr) else $error("no error");
   AST_MAPPED: assert property (psel && penable && paddr == 12'h040 |-> !pslverr) else $error("bad error");
   AST_MODE_LATCH: assert property ($fell(rst) |-> ##[1:5] specialMode == !modePin) else $error("pin lost");
   AST_NORMAL_KEEPS: assert property (!specialMode |=> !specialMode) else $error("mode back");
   AST_SECURED: assert property (secured && wr && paddr == 12'h02c |=> $stable(specialMode))
      else $error("mode moved");
   AST_PAGE_RESET: assert property ($fell(rst) |-> farPageRead == 8'hfe) else $error("page reset");
   AST_FAR_WRITE: assert property (clkEn && farPageWrite |=> farPageRead == $past(farPageData))
      else $error("far page lost");
   cover property (wr && paddr == 12'h02c && !specialMode);
   cover property (farPageWrite);
   cover property (secured && wr);
endmodule // mmp_checker

// ===== verification/mmp_cpu_model.sv
// Purpose: cpu side far call page writes
// Assumes: one page write per call request
// Notes:   idle data toggles, so every second idle cycle repeats the last page
`timescale 1ns/1ps
module mmp_cpu_model (
   input  wire       clk_sys,
   input  wire       callReq,
   input  wire [7:0] callPage,
   output reg        farPageWrite = 1'b0,
   output reg  [7:0] farPageData = 8'h00
);
   always @(posedge clk_sys) begin
      farPageWrite <= callReq;
      farPageData  <= callReq ? callPage : ~farPageData;
   end
endmodule // mmp_cpu_model

// ===== verification/test_memory_map_page_registers.sv
// Purpose: register and far page bench
// Assumes: apb master, bounded wait for pready
// Notes:   visibility seen through readback and the program info row hit
`timescale 1ns/1ps
module test_memory_map_page_registers;
   reg         clk_sys, rst, modePin, secured, psel, penable, pwrite, globalInstr, directMode, callReq, se;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, q;
   reg  [15:0] localAddr;
   reg  [7:0]  callPage;
   wire        pready, pslverr, farPageWrite, specialMode, progInfoRowHit_r;
   wire [31:0] prdata;
   wire [7:0]  farPageData, farPageRead;
   wire [22:0] globalAddr_r;
   integer     error_cnt = 0, checks_done = 0, n;
   mmp_memory_map_page_registers dut (.*, .clkEn(1'b1), .pstrb(4'hf), .scratchRamVisible(),
      .dataInfoRowVisible(), .programInfoRowVisible());
   mmp_cpu_model cpu (.*);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task end_sim; begin
      if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   end endtask
   task chk(input [31:0] s, input [31:0] e); begin
      checks_done = checks_done + 1;
      if (s !== e) begin error_cnt = error_cnt + 1; $display("wrong value %0t %h %h", $time, s, e); end
   end endtask
   // idle edge first, so psel never falls and rises in one step
   task ap(input w, input [11:0] a, input [7:0] d); begin
      @(posedge clk_sys) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
      @(posedge clk_sys) penable <= 1'b1;
      n = 0;
      do begin @(posedge clk_sys); n = n + 1; end while (pready !== 1'b1 && n < 50);
      if (n == 50) begin error_cnt = error_cnt + 1; end_sim; end
      q = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
   end endtask
   task rd(input [11:0] a, input [7:0] e); begin
      ap(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   end endtask
   task rs(input p); begin
      {rst, modePin} <= {1'b1, p};
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
   end endtask
   // registered outputs looked at mid-cycle
   task wt; begin repeat (3) @(posedge clk_sys); @(negedge clk_sys); end endtask
   initial begin
      {rst, modePin, secured, psel, penable, pwrite, globalInstr, directMode, callReq} = 9'h100;
      {paddr, pwdata, localAddr, callPage} = 68'h0;
      rs(1'b0);
      rd(12'h02c, 8'h00);
      rd(12'h054, 8'hfe);
      ap(1'b1, 12'h044, 8'h80);
      ap(1'b1, 12'h044, 8'h81);
      rd(12'h044, 8'h81);
      ap(1'b1, 12'h040, 8'hff);
      rd(12'h040, 8'h7f);
      {globalInstr, localAddr} <= {1'b1, 16'h5000};
      wt;
      chk({9'h0, globalAddr_r}, 32'h7f5000);
      @(posedge clk_sys) {directMode, localAddr} <= {1'b1, 16'h0042};
      wt;
      chk({9'h0, globalAddr_r}, 32'h7f8142);
      ap(1'b1, 12'h04c, 8'hff);
      rd(12'h04c, 8'hb0);
      ap(1'b1, 12'h040, 8'h40);
      {directMode, localAddr} <= {1'b0, 16'h3fff};
      wt;
      chk({31'h0, progInfoRowHit_r}, 32'h1);
      @(posedge clk_sys) {callReq, callPage} <= {1'b1, 8'h3c};
      @(posedge clk_sys) callReq <= 1'b0;
      wt;
      chk({24'h0, farPageRead}, 32'h3c);
      rd(12'h054, 8'h3c);
      {globalInstr, localAddr} <= {1'b0, 16'h8123};
      wt;
      chk({9'h0, globalAddr_r}, 32'h4f0123);
      @(posedge clk_sys) localAddr <= 16'hc005;
      wt;
      chk({9'h0, globalAddr_r}, 32'h7fc005);
      ap(1'b0, 12'h0f0, 8'h00);
      chk({31'h0, se}, 32'h1);
      secured <= 1'b1;
      ap(1'b1, 12'h02c, 8'h80);
      rd(12'h02c, 8'h00);
      secured <= 1'b0;
      ap(1'b1, 12'h02c, 8'h80);
      ap(1'b1, 12'h02c, 8'h00);
      rd(12'h02c, 8'h80);
      rs(1'b1);
      rd(12'h02c, 8'h80);
      ap(1'b1, 12'h044, 8'h12);
      ap(1'b1, 12'h044, 8'h34);
      rd(12'h044, 8'h12);
      end_sim;
   end
endmodule // test_memory_map_page_registers
bind mmp_memory_map_page_registers mmp_checker chk_i (.*);
